/* File: logic/pmv_pkg.sv */
package pmv_pkg;

  // ----------------------------------------
  // clock and switching interval
  // ----------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int FSW_DEFAULT_HZ = 1_000_000;
  localparam int PERIOD_CYC_DEFAULT = CLK_HZ / FSW_DEFAULT_HZ;
  localparam int PERIOD_CYC_MIN = 2;

  // ----------------------------------------
  // reference code decoding
  // ----------------------------------------
  localparam logic [7:0] PRI_FIRST_CODE = 8'h02;
  // reference in 6.25 mV steps: 256 steps is 1.60000 V
  localparam logic [8:0] PRI_TOP_STEPS = 9'h100;
  localparam int CODE_TOP_POS = 7;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [8:0] REF_RESET = 9'h000;
  // edges after reset release before the synchronised strap is valid
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  typedef enum logic [1:0] {
    PMV_TBL_PRI,
    PMV_TBL_5BIT,
    PMV_TBL_6BIT
  } pmv_tbl_t;

  typedef enum logic [1:0] {
    PMV_ST_ARMED,
    PMV_ST_HIGH,
    PMV_ST_DONE
  } pmv_st_t;

endpackage

/* File: logic/pmv_sync.sv */
`timescale 1ns/1ps
module pmv_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] stage1;

  initial begin
    if (W < 1) $error("pmv_sync: W must be at least 1");
  end

  // first stage is read only by the second
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      stage1 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule

/* File: logic/pmv_top.sv */
`timescale 1ns/1ps
// Functional notes
// - Each pulse interval lasts one period set by the frequency-set input.
// - The pulse may rise anywhere in an interval and fall right after rising.
// - At interval start the pulse stays low while the amp is below the ramp.
// - A low pulse turns the upper switch off and the lower switch on.
// - Amplifier crossing the ramp raises the pulse, upper on and lower off.
// - The pulse stays high until the amp crosses the ramp again, then falls.
// - Only one rising edge per interval, re-armed at the next interval start.
// - The strap and the top code bit pick the primary, 5-bit or 6-bit table.
// - Primary codes 0 and 1 are off, code 2 is 1.6 V, then 6.25 mV less a step.
module pmv_top #(
  parameter int CW = 16,
  parameter int PERIOD_CYC = pmv_pkg::PERIOD_CYC_DEFAULT
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [CW-1:0] freq_set_pin_i,
  input wire logic amp_above_ramp_i,
  input wire logic [7:0] code_i,
  input wire logic strap_resistor_i,
  output logic pwm_o,
  output logic upper_on_o,
  output logic lower_on_o,
  output logic interval_start_o,
  output logic output_off_o,
  output logic [8:0] reference_level_o,
  output pmv_pkg::pmv_tbl_t table_sel_o
);
  import pmv_pkg::*;

  // ----------------------------------------
  // elaboration checks
  // ----------------------------------------
  initial begin
    if (CW < 2) $error("pmv_top: CW must be at least 2");
    if (PERIOD_CYC < PERIOD_CYC_MIN) $error("pmv_top: PERIOD_CYC too small");
    if (PERIOD_CYC >= (1 << CW)) $error("pmv_top: PERIOD_CYC exceeds CW");
  end

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [CW-1:0] fs_s;
  logic cmp_s;
  logic [7:0] code_s;
  logic strap_s;

  pmv_sync #(
    .W(CW + 10)
  ) u_sync (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .async_i({freq_set_pin_i, amp_above_ramp_i, code_i, strap_resistor_i}),
    .sync_o({fs_s, cmp_s, code_s, strap_s})
  );

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic [CW-1:0] period;
    pmv_st_t st;
    logic pwm;
    logic [1:0] settle;
    logic strap_seen;
    logic strap;
    pmv_tbl_t tbl;
    logic off;
    logic [8:0] ref_lvl;
  } pmv_state_t;

  pmv_state_t cur;
  pmv_state_t next_cur;

  localparam logic [CW-1:0] PERIOD_INIT = CW'(PERIOD_CYC);
  localparam logic [CW-1:0] PERIOD_FLOOR = CW'(PERIOD_CYC_MIN);

  logic start;
  assign start = (cur.cnt == '0);

  always_comb begin
    pmv_st_t eff;
    eff = cur.st;
    next_cur = cur;

    // interval timer; new period only at the wrap so an interval never tears
    if (cur.cnt == cur.period - CW'(1)) begin
      next_cur.cnt = '0;
      next_cur.period = (fs_s < PERIOD_FLOOR) ? PERIOD_FLOOR : fs_s;
    end else begin
      next_cur.cnt = cur.cnt + CW'(1);
    end

    // a pulse spanning the boundary keeps its edge; otherwise re-arm
    if (start && cur.st == PMV_ST_DONE) begin
      eff = PMV_ST_ARMED;
    end

    case (eff)
      PMV_ST_ARMED: begin
        if (cmp_s && !cur.off) begin
          next_cur.st = PMV_ST_HIGH;
          next_cur.pwm = 1'b1;
        end else begin
          next_cur.st = PMV_ST_ARMED;
          next_cur.pwm = 1'b0;
        end
      end
      PMV_ST_HIGH: begin
        if (!cmp_s || cur.off) begin
          next_cur.st = PMV_ST_DONE;
          next_cur.pwm = 1'b0;
        end
      end
      default: begin
        // no second rise until the next interval
        next_cur.st = PMV_ST_DONE;
        next_cur.pwm = 1'b0;
      end
    endcase

    // strap is caught once; the synchroniser still shows its reset value
    // for two edges after release, so wait for it to flush
    if (cur.settle != STRAP_SETTLE) begin
      next_cur.settle = cur.settle + 2'h1;
    end else if (!cur.strap_seen) begin
      next_cur.strap_seen = 1'b1;
      next_cur.strap = strap_s;
    end

    // table select follows the top code bit live in strap-high mode
    if (!cur.strap) begin
      next_cur.tbl = PMV_TBL_PRI;
    end else if (code_s[CODE_TOP_POS]) begin
      next_cur.tbl = PMV_TBL_5BIT;
    end else begin
      next_cur.tbl = PMV_TBL_6BIT;
    end

    // only the primary table is decoded here; other tables hold level zero
    if (next_cur.tbl != PMV_TBL_PRI) begin
      next_cur.off = 1'b0;
      next_cur.ref_lvl = REF_RESET;
    end else if (code_s < PRI_FIRST_CODE) begin
      next_cur.off = 1'b1;
      next_cur.ref_lvl = REF_RESET;
    end else begin
      next_cur.off = 1'b0;
      next_cur.ref_lvl = PRI_TOP_STEPS - 9'(code_s - PRI_FIRST_CODE);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cur.cnt <= '0;
      cur.period <= PERIOD_INIT;
      cur.st <= PMV_ST_ARMED;
      cur.pwm <= 1'b0;
      cur.settle <= 2'h0;
      cur.strap_seen <= 1'b0;
      cur.strap <= 1'b0;
      cur.tbl <= PMV_TBL_PRI;
      cur.off <= 1'b1;
      cur.ref_lvl <= REF_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign pwm_o = cur.pwm;
  assign upper_on_o = cur.pwm;
  assign lower_on_o = !cur.pwm;
  assign interval_start_o = start;
  assign output_off_o = cur.off;
  assign reference_level_o = cur.ref_lvl;
  assign table_sel_o = cur.tbl;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [1:0] rises;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rises <= 2'h0;
    end else if (start) begin
      rises <= {1'b0, next_cur.pwm && !cur.pwm};
    end else if (next_cur.pwm && !cur.pwm && rises != 2'h3) begin
      rises <= rises + 2'h1;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_wrap;
    (cur.cnt == cur.period - CW'(1)) |=> (cur.cnt == '0);
  endproperty
  a_wrap: assert property (p_wrap) else $error("interval did not wrap");

  property p_fast_fall;
    (cur.st == PMV_ST_HIGH && !cmp_s) |=> !pwm_o ##0 (cur.st == PMV_ST_DONE);
  endproperty
  a_fast_fall: assert property (p_fast_fall) else $error("late fall");

  property p_start_low;
    (start && !cmp_s && cur.st != PMV_ST_HIGH) |=> !pwm_o;
  endproperty
  a_start_low: assert property (p_start_low) else $error("pulse at start");

  property p_drive;
    (upper_on_o == pwm_o) && (lower_on_o == !pwm_o);
  endproperty
  a_drive: assert property (p_drive) else $error("switch drive wrong");

  property p_rise;
    (cur.st == PMV_ST_ARMED && cmp_s && !cur.off) |=> pwm_o ##1 1'b1;
  endproperty
  a_rise: assert property (p_rise) else $error("pulse did not rise");

  property p_hold;
    (pwm_o && cmp_s && !cur.off) |=> pwm_o;
  endproperty
  a_hold: assert property (p_hold) else $error("pulse fell early");

  property p_one_rise;
    rises <= 2'h1;
  endproperty
  a_one_rise: assert property (p_one_rise) else $error("double pulse");

  property p_table;
    cur.strap_seen |=> (table_sel_o == (!$past(cur.strap) ? PMV_TBL_PRI :
      ($past(code_s[CODE_TOP_POS]) ? PMV_TBL_5BIT : PMV_TBL_6BIT)));
  endproperty
  a_table: assert property (p_table) else $error("wrong table");

  property p_decode;
    (cur.strap_seen && !cur.strap && code_s >= PRI_FIRST_CODE) |=>
      (!output_off_o && reference_level_o ==
       PRI_TOP_STEPS - 9'($past(code_s) - PRI_FIRST_CODE));
  endproperty
  a_decode: assert property (p_decode) else $error("bad reference");

  property p_off;
    (cur.strap_seen && !cur.strap && code_s < PRI_FIRST_CODE) |=>
      output_off_o ##1 !pwm_o;
  endproperty
  a_off: assert property (p_off) else $error("off code not honoured");
endmodule

/* File: bench/pmv_code_src.sv */
`timescale 1ns/1ps
// ----------------------------------------
// voltage code source
// ----------------------------------------
module pmv_code_src (
  input wire logic sys_clk_i,
  input wire logic [7:0] want_i,
  output logic [7:0] code_o = 8'h00
);
  // plain logic levels only, never above the supply
  always @(posedge sys_clk_i) begin
    code_o <= want_i;
  end
endmodule

/* File: bench/test_pulse_modulator_vid_decode.sv */
`timescale 1ns/1ps
module test_pulse_modulator_vid_decode;
  import pmv_pkg::*;
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  n_errors++; $display("Error %s expected %0h seen %0h", n, e, g); \
  end end

  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic strap = 1'b0;
  logic amp = 1'b0;
  logic [15:0] freq = 16'h0005;
  logic [7:0] want = 8'h02;
  logic [7:0] code;
  logic pwm, upper, lower, istart, off;
  logic [8:0] ref_lvl;
  pmv_tbl_t tbl;
  logic [7:0] lst[5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'hFF};
  int n_errors = 0;
  int comparisons = 0;
  int s1, s2, mst;
  logic mp;

  always #12.5 sys_clk = ~sys_clk;

  pmv_code_src i_src (.sys_clk_i(sys_clk), .want_i(want), .code_o(code));
  pmv_top #(.PERIOD_CYC(6)) i_dut (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .freq_set_pin_i(freq),
    .amp_above_ramp_i(amp), .code_i(code), .strap_resistor_i(strap),
    .pwm_o(pwm), .upper_on_o(upper), .lower_on_o(lower),
    .interval_start_o(istart), .output_off_o(off),
    .reference_level_o(ref_lvl), .table_sel_o(tbl)
  );

  // ----------------------------------------
  // pulse model
  // ----------------------------------------
  // mirrors the two-stage sync, so the pulse lags amp by three edges
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      s1 = 0;
      s2 = 0;
      mst = 0;
    end else begin
      // re-arm first: a rise may land on the interval start itself
      if (mst == 2 && istart) mst = 0;
      if (mst == 0 && s2 != 0) mst = 1;
      else if (mst == 1 && s2 == 0) mst = 2;
      s2 = s1;
      s1 = amp;
    end
    mp = (mst == 1);
    #1;
    `CHK("pwm", mp, pwm)
    `CHK("upper", mp, upper)
    `CHK("lower", !mp, lower)
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // strap is caught once after reset, so hold it across the pulse
  task automatic do_reset(logic s);
    strap <= s;
    rst_n <= 1'b0;
    tick(5);
    rst_n <= 1'b1;
    tick(1);
  endtask

  // first intervals may still run on the old period
  task automatic per(logic [15:0] f, int e);
    int n;
    freq <= f;
    for (int k = 0; k < 4; k++) begin
      n = 0;
      do begin
        tick(1);
        #1;
        n++;
      end while (istart !== 1'b1 && n < 50);
    end
    `CHK("period", e, n)
    tick(1);
  endtask

  task automatic dec(logic [7:0] c);
    pmv_tbl_t t;
    logic [8:0] r;
    t = !strap ? PMV_TBL_PRI : (c[7] ? PMV_TBL_5BIT : PMV_TBL_6BIT);
    r = (strap || c < 8'h02) ? 9'h000 : 9'h102 - c;
    want <= c;
    tick(6);
    #1;
    `CHK("off", !strap && c < 8'h02, off)
    `CHK("reference", r, ref_lvl)
    `CHK("table", t, tbl)
    tick(1);
  endtask

  task automatic conclude();
    $display("n_errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h93F47B44));
    do_reset(1'b0);
    per(16'h0001, 2);
    per(16'h0005, 5);
    // short period makes random edges hit interval starts often
    repeat (60) begin
      amp <= 1'($urandom_range(0, 1));
      tick($urandom_range(1, 8));
    end
    amp <= 1'b0;
    per(16'h0028, 40);
    amp <= 1'b1;
    tick(5);
    amp <= 1'b0;
    tick(5);
    amp <= 1'b1;
    tick(5);
    amp <= 1'b0;
    tick(45);
    foreach (lst[i]) dec(lst[i]);
    repeat (20) dec(8'($urandom_range(0, 255)));
    do_reset(1'b1);
    dec(8'h80);
    dec(8'h7F);
    repeat (6) dec(8'($urandom_range(0, 255)));
    conclude();
  end

  // a few thousand cycles is far beyond the whole sequence
  initial begin
    #(25 * 4000);
    n_errors++;
    conclude();
  end
endmodule
